// ==== bench/clc_core_props.sv ====
// clc_core_props.sv: temporal checks on the lcd controller core ports
// assumes binding onto clc_core, one clock, async active-high reset
`timescale 1ns/1ps
module clc_core_props #(
  parameter int FRAME_DIV = 16
) (
  input wire       sys_clk_i,
  input wire       rst_i,
  input wire       power_down_input_i,
  input wire       wr_stb_i,
  input wire       rd_stb_i,
  input wire       register_select_i,
  input wire [7:0] wr_data_i,
  input wire [1:0] mux_rate_i,
  input wire       icon_mode_i,
  input wire       vset_a_we_i,
  input wire       rd_valid_o,
  input wire       busy_o,
  input wire       frame_tick_o,
  input wire       osc_run_o,
  input wire       bias_four_level_o,
  input wire       gen_enable_o,
  input wire [5:0] gen_setting_o,
  input wire       outputs_grounded_o,
  input wire       ready_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] gap_q;
  logic        seen_q;
  // the divider halts in power-down, so the first tick after it is not timed
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      gap_q <= 16'h0000;
      seen_q <= 1'b0;
    end
    else
    begin
      gap_q <= frame_tick_o ? 16'h0000 : gap_q + 16'h0001;
      seen_q <= frame_tick_o ? 1'b1 : (seen_q && !outputs_grounded_o);
    end
  sequence s_int_reset;
    (busy_o && !ready_o) [*3];
  endsequence
  a_reset_ready: assert property ($fell(rst_i) |-> s_int_reset ##[1:3] ready_o)
    else $error("internal reset length wrong");
  a_status_answer: assert property (rd_stb_i && !register_select_i |=> rd_valid_o)
    else $error("status read not answered next cycle");
  a_busy_instr: assert property (wr_stb_i && ready_o && !register_select_i |-> ##[1:3] busy_o)
    else $error("instruction did not raise busy");
  a_frame_period: assert property (frame_tick_o && seen_q |-> gap_q == FRAME_DIV - 1)
    else $error("frame tick spacing wrong");
  a_bias_four: assert property ((mux_rate_i == 2'h2) [*3] |-> bias_four_level_o)
    else $error("four-level bias not chosen");
  a_bias_five: assert property ((mux_rate_i < 2'h2) [*3] |-> !bias_four_level_o)
    else $error("five-level bias not chosen");
  a_gen_zero_off: assert property (gen_setting_o == 6'h00 |-> !gen_enable_o)
    else $error("generator on with zero setting");
  a_grounded_pd: assert property (power_down_input_i [*6] |-> outputs_grounded_o && !osc_run_o)
    else $error("power-down not applied");
  a_vset_load: assert property (vset_a_we_i && !icon_mode_i |=> ##1 gen_setting_o == $past(wr_data_i[5:0], 2))
    else $error("supply setting not loaded");
endmodule // clc_core_props

bind clc_core clc_core_props #(.FRAME_DIV(FRAME_DIV)) clc_core_props_inst (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .power_down_input_i(power_down_input_i), .wr_stb_i(wr_stb_i),
  .rd_stb_i(rd_stb_i), .register_select_i(register_select_i),
  .wr_data_i(wr_data_i), .mux_rate_i(mux_rate_i),
  .icon_mode_i(icon_mode_i), .vset_a_we_i(vset_a_we_i),
  .rd_valid_o(rd_valid_o), .busy_o(busy_o), .frame_tick_o(frame_tick_o),
  .osc_run_o(osc_run_o), .bias_four_level_o(bias_four_level_o),
  .gen_enable_o(gen_enable_o), .gen_setting_o(gen_setting_o),
  .outputs_grounded_o(outputs_grounded_o), .ready_o(ready_o)
);

// ==== bench/clc_host.sv ====
// clc_host.sv: host microcontroller model on the core's strobe bus
// assumes the bench calls its tasks; outputs change on falling edges
`timescale 1ns/1ps
module clc_host (
  input  wire       sys_clk_i,
  input  wire       ready_i,
  input  wire       busy_i,
  input  wire       rd_valid_i,
  input  wire [7:0] rd_data_i,
  output reg        wr_stb_o,
  output reg        rd_stb_o,
  output reg        rs_o,
  output reg  [7:0] data_o,
  output reg        va_we_o,
  output reg        vb_we_o
);
  initial {wr_stb_o, rd_stb_o, va_we_o, vb_we_o, rs_o, data_o} = 13'h1ff;
  // released select and data lines float to their pull-ups
  task automatic put(input logic rs, input logic [7:0] d);
    @(negedge sys_clk_i);
    while (!ready_i)
      @(negedge sys_clk_i);
    rs_o = rs;
    data_o = d;
    wr_stb_o = 1'b1;
    @(negedge sys_clk_i);
    wr_stb_o = 1'b0;
    rs_o = 1'b1;
    data_o = 8'hff;
  endtask
  task automatic get(input logic rs, output logic [7:0] d);
    int n;
    n = 0;
    @(negedge sys_clk_i);
    rs_o = rs;
    rd_stb_o = 1'b1;
    @(negedge sys_clk_i);
    rd_stb_o = 1'b0;
    while (!rd_valid_i && n < 4)
    begin
      @(negedge sys_clk_i);
      n++;
    end
    d = rd_valid_i ? rd_data_i : 8'hxx;
    rs_o = 1'b1;
  endtask
  task automatic idle;
    int n;
    n = 0;
    repeat (3) @(negedge sys_clk_i);
    while ((busy_i || !ready_i) && n < 200)
    begin
      @(negedge sys_clk_i);
      n++;
    end
  endtask
  task automatic setv(input logic b, input logic [5:0] v);
    @(negedge sys_clk_i);
    data_o = {2'b00, v};
    va_we_o = !b;
    vb_we_o = b;
    @(negedge sys_clk_i);
    {va_we_o, vb_we_o} = 2'b00;
    data_o = 8'hff;
  endtask
endmodule // clc_host

// ==== bench/tb_top.sv ====
// tb_top.sv: self-checking bench for the lcd controller core
// assumes clc_host drives the bus side; frame divider shortened to 16
`timescale 1ns/1ps
module tb_top;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       pd = 1'b0;
  logic [1:0] scr = 2'h0;
  logic [1:0] mux = 2'h0;
  logic       icon = 1'b0;
  logic       down = 1'b0;
  logic       shw = 1'b0;
  logic       shr = 1'b0;
  wire        wr_stb, rd_stb, rs, va_we, vb_we, rd_valid, busy, osc;
  wire        bias4, gen_en, gnd, cur_on, ready;
  wire  [7:0] wd, rd;
  wire  [5:0] gen_set;
  wire  [6:0] cur_addr;
  wire  [6:0] ln_start;
  int         errors = 0;
  int         n_checks = 0;
  int         cyc = 0;
  logic [7:0] d;
  always #25 sys_clk = ~sys_clk;
  clc_core #(.FRAME_DIV(16)) clc_core_inst (
    .sys_clk_i(sys_clk), .rst_i(rst), .power_down_input_i(pd),
    .wr_stb_i(wr_stb), .rd_stb_i(rd_stb), .register_select_i(rs),
    .wr_data_i(wd), .screen_mode_i(scr), .mux_rate_i(mux),
    .icon_mode_i(icon), .step_down_i(down), .vset_a_we_i(va_we),
    .vset_b_we_i(vb_we), .shift_we_i(shw), .shift_right_i(shr),
    .rd_data_o(rd), .rd_valid_o(rd_valid), .busy_o(busy),
    .frame_tick_o(), .osc_run_o(osc), .bias_four_level_o(bias4),
    .gen_enable_o(gen_en), .gen_setting_o(gen_set),
    .outputs_grounded_o(gnd), .cursor_on_o(cur_on),
    .cursor_addr_o(cur_addr), .line_start_o(ln_start), .ready_o(ready));
  clc_host host_inst (
    .sys_clk_i(sys_clk), .ready_i(ready), .busy_i(busy),
    .rd_valid_i(rd_valid), .rd_data_i(rd), .wr_stb_o(wr_stb),
    .rd_stb_o(rd_stb), .rs_o(rs), .data_o(wd), .va_we_o(va_we),
    .vb_we_o(vb_we));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors=%0d checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      wrap_up;
    end
  end
  task automatic t_wrap;
    logic [1:0] m [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
    logic [6:0] a [4] = '{7'h4f, 7'h27, 7'h67, 7'h27};
    logic [6:0] nx [4] = '{7'h00, 7'h40, 7'h00, 7'h00};
    for (int i = 0; i < 4; i++)
    begin
      scr = m[i];
      host_inst.put(1'b0, {1'b1, a[i]});
      host_inst.idle;
      host_inst.put(1'b1, 8'hc0 + 8'(i));
      host_inst.idle;
      host_inst.get(1'b0, d);
      chk(d, {1'b0, nx[i]});
      host_inst.put(1'b0, {1'b1, a[i]});
      host_inst.idle;
      host_inst.get(1'b1, d);
      chk(d, 8'hc0 + 8'(i));
    end
  endtask
  task automatic t_ram;
    scr = 2'h0;
    host_inst.put(1'b0, 8'ha8);
    host_inst.put(1'b1, 8'haa);
    host_inst.put(1'b0, 8'hc0);
    host_inst.put(1'b1, 8'hbb);
    host_inst.idle;
    host_inst.put(1'b0, 8'ha8);
    host_inst.idle;
    host_inst.get(1'b1, d);
    chk(d, 8'haa);
    host_inst.put(1'b0, 8'hc0);
    host_inst.idle;
    host_inst.get(1'b1, d);
    chk(d, 8'hbb);
  endtask
  task automatic t_shift;
    logic       dir [3] = '{1'b0, 1'b1, 1'b1};
    logic [6:0] want [3] = '{7'h27, 7'h00, 7'h01};
    scr = 2'h1;
    repeat (2) @(negedge sys_clk);
    chk({1'b0, ln_start}, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      shr = dir[i];
      shw = 1'b1;
      @(negedge sys_clk);
      shw = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk({1'b0, ln_start}, {1'b0, want[i]});
    end
  endtask
  task automatic t_addr;
    host_inst.put(1'b0, 8'h85);
    host_inst.get(1'b0, d);
    chk(d, 8'h85);
    host_inst.idle;
    host_inst.get(1'b0, d);
    chk(d, 8'h05);
    chk({cur_on, cur_addr}, 8'h85);
    down = 1'b1;
    host_inst.put(1'b1, 8'h5a);
    host_inst.idle;
    host_inst.get(1'b0, d);
    chk(d, 8'h04);
    down = 1'b0;
    host_inst.put(1'b0, 8'h41);
    host_inst.idle;
    chk({7'h0, cur_on}, 8'h00);
    host_inst.get(1'b0, d);
    chk(d, 8'h01);
  endtask
  task automatic t_bias;
    for (int i = 0; i < 3; i++)
    begin
      mux = 2'(i);
      repeat (3) @(negedge sys_clk);
      chk({7'h0, bias4}, {7'h0, i == 2});
    end
  endtask
  task automatic t_vset;
    host_inst.setv(1'b0, 6'h2a);
    repeat (3) @(negedge sys_clk);
    chk({1'b0, gen_en, gen_set}, 8'h6a);
    host_inst.setv(1'b1, 6'h00);
    icon = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk({7'h0, gen_en}, 8'h00);
    host_inst.setv(1'b1, 6'h3f);
    repeat (3) @(negedge sys_clk);
    chk({1'b0, gen_en, gen_set}, 8'h7f);
    icon = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk({1'b0, gen_en, gen_set}, 8'h6a);
  endtask
  task automatic t_pd;
    pd = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk({6'h0, gnd, osc}, 8'h02);
    host_inst.put(1'b0, 8'h8a);
    host_inst.idle;
    host_inst.get(1'b0, d);
    chk(d, 8'h0a);
    pd = 1'b0;
    repeat (8) @(negedge sys_clk);
    chk({6'h0, gnd, osc}, 8'h01);
  endtask
  initial
  begin
    repeat (2) @(negedge sys_clk);
    chk({6'h0, busy, gnd}, 8'h03);
    rst = 1'b0;
    host_inst.idle;
    chk({6'h0, ready, gnd}, 8'h02);
    t_wrap;
    t_ram;
    t_addr;
    t_shift;
    t_bias;
    t_vset;
    t_pd;
    wrap_up;
  end
endmodule // tb_top

// ==== hw/clc_core.v ====
// clc_core.v: control core of a character lcd controller
// assumes a bus front end that delivers one-cycle access strobes
// synchronous to sys_clk_i, and external analog/pattern logic
`timescale 1ns/1ps
`include "clc_regs.vh"

module clc_core #(
  parameter FRAME_DIV = `CLC_FRAME_DIV,
  parameter BUSY_CYC  = `CLC_BUSY_CYC,
  parameter FIFO_DEPTH = 16
) (
  input  wire       sys_clk_i,
  input  wire       rst_i,
  input  wire       power_down_input_i,
  input  wire       wr_stb_i,
  input  wire       rd_stb_i,
  input  wire       register_select_i,
  input  wire [7:0] wr_data_i,
  input  wire [1:0] screen_mode_i,
  input  wire [1:0] mux_rate_i,
  input  wire       icon_mode_i,
  input  wire       step_down_i,
  input  wire       vset_a_we_i,
  input  wire       vset_b_we_i,
  input  wire       shift_we_i,
  input  wire       shift_right_i,
  output reg  [7:0] rd_data_o,
  output reg        rd_valid_o,
  output reg        busy_o,
  output reg        frame_tick_o,
  output reg        osc_run_o,
  output reg        bias_four_level_o,
  output reg        gen_enable_o,
  output reg  [5:0] gen_setting_o,
  output reg        outputs_grounded_o,
  output reg        cursor_on_o,
  output reg  [6:0] cursor_addr_o,
  output reg  [6:0] line_start_o,
  output reg        ready_o
);
  // instruction codes are decoded elsewhere; only address loads live here
  reg                     pd_s1_q, pd_s2_q, pd_s3_q, pd_q;
  reg [2:0]               rst_cnt_q;
  reg [5:0]               vset_a_q, vset_b_q;
  reg [7:0]               instruction_holding_q;
  reg [7:0]               data_holding_q;
  reg [6:0]               address_pointer_q;
  reg                     ptr_in_cram_q;
  reg [6:0]               shift_q;
  reg [11:0]              div_q;
  reg [3:0]               busy_cnt_q;
  reg [7:0]               display_ram [0:`CLC_DRAM_DEPTH-1];
  reg [7:0]               character_ram [0:`CLC_CRAM_DEPTH-1];
  reg                     rd_pend_q;
  reg [4:0]               fill_q;
  wire                    in_rst;
  wire                    push_ok;
  wire [4:0]              fill_d;
  wire [6:0]              dram_at;
  wire                    fifo_ready;
  wire                    fifo_valid;
  wire [8:0]              fifo_data;
  wire                    take;
  wire                    is_instr;
  wire                    is_data;
  wire [7:0]              cmd;

  // counts sized here so no integer lands on a narrow register
  localparam [2:0] RST_CYC = `CLC_RST_CYC;

  assign in_rst = (rst_cnt_q != 3'h0);

  // host writes queue here; data and instructions keep their order
  clc_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH),
    .AW    (4)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .in_data_i   ({register_select_i, wr_data_i}),
    .in_valid_i  (wr_stb_i),
    .in_ready_o  (fifo_ready),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (take)
  );

  // entries drain only when not busy, so a slow core back-pressures
  assign take     = fifo_valid & ~in_rst & (busy_cnt_q == 4'h0);
  assign is_instr = take & ~fifo_data[8];
  assign is_data  = take & fifo_data[8];
  assign cmd      = fifo_data[7:0];

  // occupancy mirror: ready_o must drop at the edge the queue fills,
  // since a write seen with ready high is counted as accepted
  assign push_ok = wr_stb_i & fifo_ready;
  assign fill_d  = (push_ok & ~take) ? fill_q + 5'h01
                 : (take & ~push_ok) ? fill_q - 5'h01
                 : fill_q;

  // sequential wrap for one access step in the active screen mode
  function [6:0] step_addr;
    input [6:0] a;
    input       down;
    input [1:0] mode;
    begin
      step_addr = down ? a - 7'h01 : a + 7'h01;
      case (mode)
        `CLC_SCR_1X32:
        begin
          if (!down && a == `CLC_ADDR_4F) step_addr = 7'h00;
          if (down && a == 7'h00) step_addr = `CLC_ADDR_4F;
        end
        `CLC_SCR_2X16:
        begin
          if (!down && a == `CLC_ADDR_27) step_addr = `CLC_ADDR_40;
          if (!down && a == `CLC_ADDR_67) step_addr = 7'h00;
          if (down && a == `CLC_ADDR_40) step_addr = `CLC_ADDR_27;
          if (down && a == 7'h00) step_addr = `CLC_ADDR_67;
        end
        default:
        begin
          if (!down && a == `CLC_ADDR_27) step_addr = 7'h00;
          if (down && a == 7'h00) step_addr = `CLC_ADDR_27;
        end
      endcase
    end
  endfunction

  // display ram index; only 2x16 packs its second line 40..67 behind
  // 00..27, the single-line modes address the array directly
  function [6:0] dram_idx;
    input [6:0] a;
    input [1:0] mode;
    begin
      if (mode == `CLC_SCR_2X16 && a >= `CLC_ADDR_40)
        dram_idx = a - 7'h18;
      else
        dram_idx = a;
    end
  endfunction

  // per-line start after shift; lines wrap within themselves
  function [6:0] line_base;
    input [6:0] sh;
    input [1:0] mode;
    begin
      if (mode == `CLC_SCR_1X32)
        line_base = sh;
      else
        line_base = (sh > `CLC_ADDR_27) ? 7'h00 : sh;
    end
  endfunction

  // display shift stays inside one line; 1x32 wraps over the whole space
  function [6:0] shift_step;
    input [6:0] sh;
    input       right;
    input [1:0] mode;
    reg   [6:0] last;
    begin
      last = (mode == `CLC_SCR_1X32) ? `CLC_ADDR_4F : `CLC_ADDR_27;
      if (right)
        shift_step = (sh >= last) ? 7'h00 : sh + 7'h01;
      else
        shift_step = (sh == 7'h00 || sh > last) ? last : sh - 7'h01;
    end
  endfunction

  // pointer after one data access; character ram ignores the screen wrap
  function [6:0] next_ptr;
    input [6:0] a;
    input       cram;
    input       down;
    input [1:0] mode;
    begin
      if (cram)
        next_ptr = down ? a - 7'h01 : a + 7'h01;
      else
        next_ptr = step_addr(a, down, mode);
    end
  endfunction

  assign dram_at = dram_idx(address_pointer_q, screen_mode_i);

  always @(posedge sys_clk_i)
  begin
    if (is_data && !ptr_in_cram_q)
      display_ram[dram_at] <= cmd;
    if (is_data && ptr_in_cram_q)
      character_ram[address_pointer_q] <= cmd;
  end

  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pd_s1_q               <= 1'b0;
      pd_s2_q               <= 1'b0;
      pd_s3_q               <= 1'b0;
      pd_q                  <= 1'b0;
      rst_cnt_q             <= RST_CYC;
      vset_a_q              <= `CLC_VSET_RST;
      vset_b_q              <= `CLC_VSET_RST;
      instruction_holding_q <= 8'h00;
      data_holding_q        <= `CLC_DH_RST;
      address_pointer_q     <= `CLC_AP_RST;
      ptr_in_cram_q         <= 1'b0;
      shift_q               <= 7'h00;
      div_q                 <= 12'h000;
      busy_cnt_q            <= 4'h0;
      rd_pend_q             <= 1'b0;
      fill_q                <= 5'h00;
      rd_data_o             <= 8'h00;
      rd_valid_o            <= 1'b0;
      busy_o                <= 1'b1;
      frame_tick_o          <= 1'b0;
      osc_run_o             <= 1'b0;
      bias_four_level_o     <= `CLC_BIAS_5LVL;
      gen_enable_o          <= 1'b0;
      gen_setting_o         <= 6'h00;
      outputs_grounded_o    <= 1'b1;
      cursor_on_o           <= 1'b0;
      cursor_addr_o         <= 7'h00;
      line_start_o          <= 7'h00;
      ready_o               <= 1'b0;
    end
    else
    begin
      // pin filter: a level counts once stages two and three agree
      pd_s1_q <= power_down_input_i;
      pd_s2_q <= pd_s1_q;
      pd_s3_q <= pd_s2_q;
      if (pd_s2_q == pd_s3_q)
        pd_q <= pd_s3_q;
      if (in_rst)
        rst_cnt_q <= rst_cnt_q - 3'h1;
      fill_q  <= fill_d;
      ready_o <= ~in_rst & (fill_d != FIFO_DEPTH[4:0]);
      // settings arrive from the command decoder with their value
      if (vset_a_we_i)
        vset_a_q <= wr_data_i[5:0];
      if (vset_b_we_i)
        vset_b_q <= wr_data_i[5:0];
      if (shift_we_i)
        shift_q <= shift_step(shift_q, shift_right_i, screen_mode_i);
      rd_valid_o <= 1'b0;
      if (busy_cnt_q != 4'h0)
        busy_cnt_q <= busy_cnt_q - 4'h1;
      if (is_instr)
      begin
        instruction_holding_q <= cmd;
        busy_cnt_q            <= BUSY_CYC[3:0];
        if (cmd[7])
        begin
          address_pointer_q <= cmd[6:0];
          ptr_in_cram_q     <= 1'b0;
        end
        else if (cmd[6])
        begin
          address_pointer_q <= {1'b0, cmd[5:0]};
          ptr_in_cram_q     <= 1'b1;
        end
      end
      else if (is_data)
      begin
        address_pointer_q <= next_ptr(address_pointer_q, ptr_in_cram_q,
                                      step_down_i, screen_mode_i);
      end
      // status answers at once; a data read is served only with an empty queue and no busy count, else dropped
      if (rd_stb_i && !register_select_i)
      begin
        rd_data_o  <= {busy_o, address_pointer_q};
        rd_valid_o <= 1'b1;
      end
      else if (rd_stb_i && !fifo_valid && busy_cnt_q == 4'h0)
      begin
        data_holding_q <= ptr_in_cram_q ? character_ram[address_pointer_q]
                        : display_ram[dram_at];
        rd_pend_q      <= 1'b1;
      end
      if (rd_pend_q)
      begin
        rd_data_o         <= data_holding_q;
        rd_valid_o        <= 1'b1;
        rd_pend_q         <= 1'b0;
        address_pointer_q <= next_ptr(address_pointer_q, ptr_in_cram_q,
                                      step_down_i, screen_mode_i);
      end
      // busy covers queued writes too, so a status poll never races them
      busy_o <= in_rst | fifo_valid | (busy_cnt_q != 4'h0) | rd_pend_q;
      // display clock keeps running only while powered up
      if (!pd_q && !in_rst)
      begin
        if (div_q == FRAME_DIV[11:0] - 12'h001)
        begin
          div_q        <= 12'h000;
          frame_tick_o <= 1'b1;
        end
        else
        begin
          div_q        <= div_q + 12'h001;
          frame_tick_o <= 1'b0;
        end
      end
      else
        frame_tick_o <= 1'b0;
      osc_run_o          <= ~pd_q;
      outputs_grounded_o <= pd_q | in_rst;
      bias_four_level_o  <= (mux_rate_i == `CLC_MUX_2) ? `CLC_BIAS_4LVL
                                                       : `CLC_BIAS_5LVL;
      gen_setting_o      <= icon_mode_i ? vset_b_q : vset_a_q;
      gen_enable_o       <= ~pd_q & (icon_mode_i ? (vset_b_q != 6'h00)
                                                 : (vset_a_q != 6'h00));
      cursor_on_o        <= ~ptr_in_cram_q & ~pd_q;
      cursor_addr_o      <= address_pointer_q;
      line_start_o       <= line_base(shift_q, screen_mode_i);
    end
  end
endmodule // clc_core

// ==== hw/clc_fifo.v ====
// clc_fifo.v: synchronous fifo with valid/ready on both sides
// assumes a single clock and an asynchronous active-high reset
`timescale 1ns/1ps
module clc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             sys_clk_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge sys_clk_i)
  begin
    if (push)
      mem[wr_q] <= in_data_i;
  end

  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      if (push & ~pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // clc_fifo

// ==== inc/clc_regs.vh ====
// clc_regs.vh: constants of the character lcd controller core
// assumes inclusion by bare name from the design files
`ifndef CLC_REGS_VH
`define CLC_REGS_VH
`define CLC_VSET_W        6
`define CLC_VSET_RST      6'h00
`define CLC_FRAME_DIV     3072
`define CLC_RST_CYC       3
`define CLC_DRAM_DEPTH    80
`define CLC_LINE1_LEN     32
`define CLC_CRAM_DEPTH    128
`define CLC_AP_W          7
`define CLC_AP_RST        7'h00
`define CLC_DH_RST        8'h00
`define CLC_STAT_BUSY_BIT 7
`define CLC_SCR_1X32      2'h0
`define CLC_SCR_2X16      2'h1
`define CLC_SCR_1X9       2'h2
`define CLC_MUX_18        2'h0
`define CLC_MUX_9         2'h1
`define CLC_MUX_2         2'h2
`define CLC_BIAS_5LVL     1'b0
`define CLC_BIAS_4LVL     1'b1
`define CLC_ADDR_4F       7'h4f
`define CLC_ADDR_27       7'h27
`define CLC_ADDR_40       7'h40
`define CLC_ADDR_67       7'h67
`define CLC_USER_CHARS    16
`define CLC_ROM_PATTERNS  240
`define CLC_BUSY_CYC      4
`endif
